// >>> src/fwsr_defs.vh
// Constants for the flash write and status controller
`ifndef FWSR_DEFS_VH
`define FWSR_DEFS_VH
// ==========================================================================
// APB register offsets
`define FWSR_REG_CTRL      12'h000
`define FWSR_REG_ADDR      12'h004
`define FWSR_REG_DATA      12'h008
`define FWSR_REG_STATUS    12'h00c
`define FWSR_REG_RDATA     12'h010
`define FWSR_REG_SECTOR    12'h014
// ==========================================================================
// Control register fields and commands
`define FWSR_CMD_W         4
`define FWSR_CMD_READ      4'h1
`define FWSR_CMD_RESET     4'h2
`define FWSR_CMD_PROGRAM   4'h3
`define FWSR_CMD_CHIP_ERS  4'h4
`define FWSR_CMD_SECT_ERS  4'h5
`define FWSR_CMD_SUSPEND   4'h6
`define FWSR_CMD_RESUME    4'h7
`define FWSR_CMD_AUTOSEL   4'h8
`define FWSR_CMD_BYP_ENTER 4'h9
`define FWSR_CMD_BYP_PROG  4'ha
`define FWSR_CMD_BYP_EXIT  4'hb
`define FWSR_CMD_POLL      4'hc
// ==========================================================================
// Status register bit positions
`define FWSR_ST_BUSY       0
`define FWSR_ST_DONE       1
`define FWSR_ST_FAIL       2
`define FWSR_ST_RDY        3
`define FWSR_ST_BYPASS     4
`define FWSR_ST_SUSP       5
`define FWSR_ST_AUTOSEL    6
// ==========================================================================
// Flash command data values and unlock addresses
`define FWSR_UNLOCK1_ADDR  20'h00555
`define FWSR_UNLOCK2_ADDR  20'h002aa
`define FWSR_D_AA          8'haa
`define FWSR_D_55          8'h55
`define FWSR_D_RESET       8'hf0
`define FWSR_D_AUTOSEL     8'h90
`define FWSR_D_PROGRAM     8'ha0
`define FWSR_D_BYPASS      8'h20
`define FWSR_D_ERASE       8'h80
`define FWSR_D_CHIP        8'h10
`define FWSR_D_SECTOR      8'h30
`define FWSR_D_SUSPEND     8'hb0
`define FWSR_D_RESUME      8'h30
`define FWSR_D_BYP_EXIT2   8'h00
// ==========================================================================
// Sector field of the flash address
`define FWSR_SECT_HI       18
`define FWSR_SECT_LO       12
// ==========================================================================
// Bus cycle timing, in clock cycles of 50 ns
`define FWSR_CYC_SETUP     2
`define FWSR_CYC_STROBE    2
`define FWSR_CYC_READ      2
`define FWSR_CYC_HOLD      1
`endif

// >>> src/fwsr_cycle.v
// One asynchronous flash bus cycle, read or write, sequenced by pclk
`timescale 1ns/100ps
`include "fwsr_defs.vh"
module fwsr_cycle #(
  parameter AW = 20,
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          start,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output wire          done,
  output reg  [DW-1:0] rdata_r,
  output reg  [AW-1:0] fl_addr_r,
  output reg  [DW-1:0] fl_dq_out_r,
  output reg           fl_dq_oe_r,
  input  wire [DW-1:0] fl_dq_in,
  output reg           fl_chip_sel_n_r,
  output reg           fl_write_en_n_r,
  output reg           fl_out_en_n_r
);
  localparam S_IDLE  = 4'b0001;
  localparam S_SETUP = 4'b0010;
  localparam S_PULSE = 4'b0100;
  localparam S_HOLD  = 4'b1000;

  reg [3:0]    state_r;
  reg [3:0]    cnt_r;
  reg          wr_r;
  reg [DW-1:0] dq_s1_r;
  reg [DW-1:0] dq_s2_r;

  assign done = (state_r == S_HOLD) && (cnt_r == 4'h0);

  // ==========================================================================
  // Data pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_r <= {DW{1'b0}};
      dq_s2_r <= {DW{1'b0}};
    end else begin
      dq_s1_r <= fl_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ==========================================================================
  // Cycle sequencer: address set first, strobe, then data kept past the rising strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= S_IDLE;
      cnt_r           <= 4'h0;
      wr_r            <= 1'b0;
      rdata_r         <= {DW{1'b0}};
      fl_addr_r       <= {AW{1'b0}};
      fl_dq_out_r     <= {DW{1'b0}};
      fl_dq_oe_r      <= 1'b0;
      fl_chip_sel_n_r <= 1'b1;
      fl_write_en_n_r <= 1'b1;
      fl_out_en_n_r   <= 1'b1;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (start) begin
            wr_r            <= wr;
            fl_addr_r       <= addr;
            fl_dq_out_r     <= wdata;
            fl_dq_oe_r      <= wr;
            fl_chip_sel_n_r <= 1'b0;
            cnt_r           <= 4'd`FWSR_CYC_SETUP;
            state_r         <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_r == 4'h0) begin
            // Address is stable before the later falling strobe
            fl_write_en_n_r <= ~wr_r;
            fl_out_en_n_r   <= wr_r;
            cnt_r           <= wr_r ? 4'd`FWSR_CYC_STROBE : 4'd`FWSR_CYC_READ + 4'd2;
            state_r         <= S_PULSE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        S_PULSE: begin
          if (cnt_r == 4'h0) begin
            // Data stays driven through the first rising strobe
            if (!wr_r)
              rdata_r <= dq_s2_r;
            fl_write_en_n_r <= 1'b1;
            fl_out_en_n_r   <= 1'b1;
            cnt_r           <= 4'd`FWSR_CYC_HOLD;
            state_r         <= S_HOLD;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt_r == 4'h0) begin
            fl_chip_sel_n_r <= 1'b1;
            fl_dq_oe_r      <= 1'b0;
            state_r         <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end
endmodule

// >>> src/fwsr_host.v
// Host controller issuing flash command sequences and status polls from APB
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "fwsr_defs.vh"
module fwsr_host #(
  parameter AW = 20,
  parameter DW = 8
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  output wire [AW-1:0] fl_addr,
  output wire [DW-1:0] fl_dq_out,
  output wire          fl_dq_oe,
  input  wire [DW-1:0] fl_dq_in,
  output wire          fl_chip_sel_n,
  output wire          fl_write_en_n,
  output wire          fl_out_en_n,
  input  wire          ready_busy_in
);
  localparam S_IDLE = 6'b000001;
  localparam S_SEQ  = 6'b000010;
  localparam S_WAIT = 6'b000100;
  localparam S_POLL = 6'b001000;
  localparam S_CHK  = 6'b010000;
  localparam S_FIN  = 6'b100000;

  reg [5:0]     state_r;
  reg [3:0]     cmd_r;
  reg [2:0]     step_r;
  reg [AW-1:0]  addr_r, cyc_addr_r, cyc_addr_nxt;
  reg [DW-1:0]  data_r, rd_r, prev_r, cyc_data_r, cyc_data_nxt;
  reg           have_prev_r, done_r, fail_r, bypass_r, susp_r, autosel_r, chk_ok_r;
  reg           rb_s1_r, rb_s2_r, cyc_start_r, cyc_wr_r, last_r, poll_r;
  reg           cyc_wr_nxt, last_nxt, poll_nxt;
  wire          cyc_done, busy, wr_en, ctrl_wr;
  wire [DW-1:0] cyc_rdata;
  assign busy    = (state_r != S_IDLE);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;
  assign ctrl_wr = wr_en && (paddr == `FWSR_REG_CTRL) && !busy;
  // Sector number of a flash address
  function [6:0] sect_of;
    input [AW-1:0] a;
    begin
      sect_of = a[`FWSR_SECT_HI:`FWSR_SECT_LO];
    end
  endfunction

  // ==========================================================================
  // Ready/busy pin synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      rb_s1_r <= ready_busy_in;
      rb_s2_r <= rb_s1_r;
    end
  end

  // ==========================================================================
  // Bus cycle engine
  fwsr_cycle #(.AW(AW), .DW(DW)) fwsr_cycle_i (
    .pclk(pclk), .presetn(presetn), .start(cyc_start_r), .wr(cyc_wr_r), .addr(cyc_addr_r), .wdata(cyc_data_r),
    .done(cyc_done), .rdata_r(cyc_rdata), .fl_addr_r(fl_addr), .fl_dq_out_r(fl_dq_out), .fl_dq_oe_r(fl_dq_oe),
    .fl_dq_in(fl_dq_in), .fl_chip_sel_n_r(fl_chip_sel_n), .fl_write_en_n_r(fl_write_en_n),
    .fl_out_en_n_r(fl_out_en_n));

  // ==========================================================================
  // Command sequence table: cycle for each step of each command
  always @* begin
    cyc_wr_nxt   = 1'b1;
    cyc_addr_nxt = `FWSR_UNLOCK1_ADDR;
    cyc_data_nxt = `FWSR_D_AA;
    last_nxt     = 1'b0;
    poll_nxt     = 1'b0;
    case (step_r)
      3'd1, 3'd4: begin
        cyc_addr_nxt = `FWSR_UNLOCK2_ADDR;
        cyc_data_nxt = `FWSR_D_55;
      end
      3'd2: cyc_data_nxt = `FWSR_D_ERASE;
      3'd5: begin
        last_nxt     = 1'b1;
        poll_nxt     = 1'b1;
        cyc_data_nxt = (cmd_r == `FWSR_CMD_SECT_ERS) ? `FWSR_D_SECTOR : `FWSR_D_CHIP;
        if (cmd_r == `FWSR_CMD_SECT_ERS)
          cyc_addr_nxt = addr_r;
      end
      default: cyc_data_nxt = `FWSR_D_AA;
    endcase
    case (cmd_r)
      `FWSR_CMD_READ, `FWSR_CMD_POLL: begin
        cyc_wr_nxt   = 1'b0;
        cyc_addr_nxt = addr_r;
        last_nxt     = 1'b1;
      end
      `FWSR_CMD_RESET, `FWSR_CMD_SUSPEND: begin
        cyc_data_nxt = (cmd_r == `FWSR_CMD_RESET) ? `FWSR_D_RESET : `FWSR_D_SUSPEND;
        last_nxt     = 1'b1;
      end
      `FWSR_CMD_RESUME: begin
        cyc_data_nxt = `FWSR_D_RESUME;
        last_nxt     = 1'b1;
        poll_nxt     = 1'b1;
      end
      `FWSR_CMD_BYP_PROG: begin
        cyc_data_nxt = (step_r == 3'd0) ? `FWSR_D_PROGRAM : data_r;
        cyc_addr_nxt = (step_r == 3'd0) ? `FWSR_UNLOCK1_ADDR : addr_r;
        last_nxt     = (step_r == 3'd1);
        poll_nxt     = (step_r == 3'd1);
      end
      `FWSR_CMD_BYP_EXIT: begin
        cyc_data_nxt = (step_r == 3'd0) ? `FWSR_D_AUTOSEL : `FWSR_D_BYP_EXIT2;
        last_nxt     = (step_r == 3'd1);
      end
      `FWSR_CMD_PROGRAM, `FWSR_CMD_AUTOSEL, `FWSR_CMD_BYP_ENTER: begin
        if (step_r == 3'd2)
          cyc_data_nxt = (cmd_r == `FWSR_CMD_PROGRAM) ? `FWSR_D_PROGRAM :
                         (cmd_r == `FWSR_CMD_AUTOSEL) ? `FWSR_D_AUTOSEL : `FWSR_D_BYPASS;
        if (step_r == 3'd3) begin
          cyc_wr_nxt   = (cmd_r == `FWSR_CMD_PROGRAM);
          cyc_addr_nxt = addr_r;
          cyc_data_nxt = data_r;
          poll_nxt     = (cmd_r == `FWSR_CMD_PROGRAM);
        end
        last_nxt = (cmd_r == `FWSR_CMD_BYP_ENTER) ? (step_r == 3'd2) : (step_r == 3'd3);
      end
      default: cyc_data_nxt = cyc_data_nxt;
    endcase
  end

  // ==========================================================================
  // Sequencer and status polling
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r     <= S_IDLE;
      cmd_r       <= 4'h0;
      step_r      <= 3'd0;
      addr_r      <= {AW{1'b0}};
      data_r      <= {DW{1'b0}};
      rd_r        <= {DW{1'b0}};
      prev_r      <= {DW{1'b0}};
      have_prev_r <= 1'b0;
      done_r      <= 1'b0;
      fail_r      <= 1'b0;
      bypass_r    <= 1'b0;
      susp_r      <= 1'b0;
      autosel_r   <= 1'b0;
      chk_ok_r    <= 1'b0;
      cyc_start_r <= 1'b0;
      cyc_wr_r    <= 1'b0;
      cyc_addr_r  <= {AW{1'b0}};
      cyc_data_r  <= {DW{1'b0}};
      last_r      <= 1'b0;
      poll_r      <= 1'b0;
    end else begin
      cyc_start_r <= 1'b0;
      if (!busy && wr_en && paddr == `FWSR_REG_ADDR)
        addr_r <= pwdata[AW-1:0];
      if (!busy && wr_en && paddr == `FWSR_REG_DATA)
        data_r <= pwdata[DW-1:0];
      case (state_r)
        S_IDLE: begin
          if (ctrl_wr) begin
            cmd_r       <= pwdata[`FWSR_CMD_W-1:0];
            step_r      <= 3'd0;
            done_r      <= 1'b0;
            fail_r      <= 1'b0;
            have_prev_r <= 1'b0;
            // Bypass program refused outside bypass mode, resume outside suspend
            if ((pwdata[`FWSR_CMD_W-1:0] == `FWSR_CMD_BYP_PROG && !bypass_r) ||
                (pwdata[`FWSR_CMD_W-1:0] == `FWSR_CMD_RESUME && !susp_r) ||
                pwdata[`FWSR_CMD_W-1:0] == 4'h0 || pwdata[`FWSR_CMD_W-1:0] > `FWSR_CMD_POLL) begin
              fail_r <= 1'b1;
              done_r <= 1'b1;
            end else begin
              state_r <= S_SEQ;
            end
          end
        end
        S_SEQ: begin
          cyc_wr_r    <= cyc_wr_nxt;
          cyc_addr_r  <= cyc_addr_nxt;
          cyc_data_r  <= cyc_data_nxt;
          last_r      <= last_nxt;
          poll_r      <= poll_nxt;
          cyc_start_r <= 1'b1;
          state_r     <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            step_r <= step_r + 3'd1;
            if (!last_r) begin
              state_r <= S_SEQ;
            end else begin
              rd_r <= cyc_rdata;
              if (cmd_r == `FWSR_CMD_RESET || cmd_r == `FWSR_CMD_AUTOSEL)
                autosel_r <= (cmd_r == `FWSR_CMD_AUTOSEL);
              // Only bypass exit leaves bypass mode, a plain reset does not
              if (cmd_r == `FWSR_CMD_BYP_ENTER || cmd_r == `FWSR_CMD_BYP_EXIT)
                bypass_r <= (cmd_r == `FWSR_CMD_BYP_ENTER);
              if (cmd_r == `FWSR_CMD_SUSPEND || cmd_r == `FWSR_CMD_RESUME)
                susp_r <= (cmd_r == `FWSR_CMD_SUSPEND);
              // Polling starts after the final write strobe has risen
              state_r <= poll_r ? S_POLL : S_FIN;
            end
          end
        end
        S_POLL: begin
          cyc_wr_r    <= 1'b0;
          cyc_addr_r  <= addr_r;
          cyc_start_r <= 1'b1;
          state_r     <= S_CHK;
        end
        S_CHK: begin
          if (cyc_done) begin
            have_prev_r <= 1'b1;
            prev_r      <= cyc_rdata;
            rd_r        <= cyc_rdata;
            // Bit 6 stopped inverting: operation over
            if (have_prev_r && (cyc_rdata[6] == prev_r[6])) begin
              if (chk_ok_r) begin
                state_r <= S_FIN;
              end else begin
                chk_ok_r <= 1'b1;
                state_r  <= S_POLL;
              end
            end else if (have_prev_r && prev_r[5] && cyc_rdata[5]) begin
              fail_r  <= 1'b1;
              state_r <= S_FIN;
            end else begin
              chk_ok_r <= 1'b0;
              state_r  <= S_POLL;
            end
          end
        end
        S_FIN: begin
          done_r   <= 1'b1;
          chk_ok_r <= 1'b0;
          state_r  <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // APB read mux
  always @* begin
    case (paddr)
      `FWSR_REG_CTRL:   prdata = {28'h0000000, cmd_r};
      `FWSR_REG_ADDR:   prdata = {{(32-AW){1'b0}}, addr_r};
      `FWSR_REG_DATA:   prdata = {{(32-DW){1'b0}}, data_r};
      `FWSR_REG_STATUS: prdata = {25'h0000000, autosel_r, susp_r, bypass_r, rb_s2_r, fail_r, done_r, busy};
      `FWSR_REG_RDATA:  prdata = {{(32-DW){1'b0}}, rd_r};
      `FWSR_REG_SECTOR: prdata = {25'h0000000, sect_of(addr_r)};
      default:          prdata = 32'h0000_0000;
    endcase
  end
endmodule

// >>> tb/fwsr_host_sva.sv
// Concurrent checks on the flash host controller ports
`timescale 1ns/100ps
module fwsr_host_sva #(
  parameter AW = 20,
  parameter DW = 8
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pready,
  input wire          pslverr,
  input wire [AW-1:0] fl_addr,
  input wire [DW-1:0] fl_dq_out,
  input wire          fl_dq_oe,
  input wire          fl_chip_sel_n,
  input wire          fl_write_en_n,
  input wire          fl_out_en_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus answer and flash strobes
  apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access stalled or refused");
  write_select_a: assert property (!fl_write_en_n |-> !fl_chip_sel_n && fl_out_en_n)
    else $error("write strobe outside chip select");
  read_float_a: assert property (!fl_out_en_n |-> !fl_dq_oe && !fl_chip_sel_n)
    else $error("host drives data during a read");
  addr_hold_a: assert property (!fl_chip_sel_n && !$past(fl_chip_sel_n) |-> $stable(fl_addr))
    else $error("address moved inside a cycle");
  data_hold_a: assert property (!fl_write_en_n |=> $stable(fl_dq_out) && fl_dq_oe)
    else $error("write data moved at strobe end");
  write_width_a: assert property ($fell(fl_write_en_n) |-> !fl_write_en_n[*3] ##1 fl_write_en_n)
    else $error("write strobe width wrong");
  read_width_a: assert property ($fell(fl_out_en_n) |-> !fl_out_en_n[*5] ##1 fl_out_en_n)
    else $error("read strobe width wrong");
  strobe_setup_a: assert property ($fell(fl_write_en_n) || $fell(fl_out_en_n) |-> !$past(fl_chip_sel_n) && $stable(fl_addr))
    else $error("strobe without address setup");
  cover property ($fell(fl_write_en_n));
  cover property ($fell(fl_out_en_n));
  cover property (psel && penable);
endmodule
bind fwsr_host fwsr_host_sva #(.AW(AW), .DW(DW)) fwsr_host_sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
  .fl_dq_oe(fl_dq_oe), .fl_chip_sel_n(fl_chip_sel_n), .fl_write_en_n(fl_write_en_n), .fl_out_en_n(fl_out_en_n));

// >>> tb/fwsr_flash_mdl.sv
// Behavioural flash device answering the host controller
`timescale 1ns/100ps
module fwsr_flash_mdl #(
  parameter [6:0] PROT   = 7'h05,
  parameter [7:0] MAN_ID = 8'h5a, // Arbitrary value
  parameter [7:0] DEV_ID = 8'h3c, // Arbitrary value
  parameter       PROG_T = 60,
  parameter       ERS_T  = 400
) (
  input  wire [19:0] addr,
  input  wire [7:0]  dq_in,
  input  wire        cs_n,
  input  wire        we_n,
  input  wire        oe_n,
  output logic [7:0] dq_o,
  output logic       rb_oe
);
  logic [7:0]   mem [0:524287];
  logic [127:0] sel;
  logic [19:0]  la;
  logic [7:0]   pd, val, last;
  logic         wr_on, rd_on, auto, byp, susp, pfail, t6, t2;
  int           cyc, prog_left, ers_left;
  initial begin
    for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
    {sel, la, pd, val, last, wr_on, rd_on, auto, byp, susp, pfail, t6, t2} = '0;
    {cyc, prog_left, ers_left} = '0;
  end
  // ==========
  // Embedded operation timing, one tick each 50 ns
  always #50 begin
    if (prog_left > 0 && !pfail) prog_left--;
    if (ers_left > 0 && !susp) ers_left--;
  end
  assign rb_oe = prog_left > 0 || (ers_left > 0 && !susp);
  // Released bus shows the inverse of the last value
  assign dq_o = rd_on ? val : ~last;
  always @(negedge we_n or negedge cs_n)
    if (!we_n && !cs_n && oe_n) begin
      la = addr;
      wr_on = 1'b1;
    end
  always @(posedge we_n or posedge cs_n)
    if (wr_on) begin
      wr_on = 1'b0;
      do_wr(la, dq_in);
    end
  always @(negedge oe_n or negedge cs_n)
    if (!oe_n && !cs_n && we_n) begin
      rd_val(addr);
      rd_on = 1'b1;
    end
  always @(posedge oe_n or posedge cs_n)
    if (rd_on) begin
      last = val;
      rd_on = 1'b0;
    end
  task automatic rd_val(input [19:0] a);
    logic s;
    s = sel[a[18:12]];
    if (prog_left > 0) val = {~pd[7], t6, pfail, 5'h00};
    else if (ers_left > 0 && !susp) val = {1'b0, t6, 3'b001, t2, 2'b00};
    else if (auto) val = a[7:0] == 8'h02 ? {7'h00, a[18:12] == PROT} : (a[7:0] == 8'h00 ? MAN_ID : DEV_ID);
    else if (ers_left > 0 && s) val = {1'b1, t6, 3'b000, t2, 2'b00};
    else val = mem[a[18:0]];
    if (rb_oe) t6 = ~t6;
    if (ers_left > 0 && s) t2 = ~t2;
  endtask
  task automatic prog(input [19:0] a, input [7:0] d);
    cyc = 0;
    pd = d;
    pfail = (mem[a[18:0]] & d) != d && a[18:12] != PROT;
    prog_left = a[18:12] == PROT ? 40 : PROG_T;
    if (!pfail && a[18:12] != PROT) mem[a[18:0]] = d;
  endtask
  task automatic erase(input [127:0] m);
    sel = m;
    ers_left = m == (128'd1 << PROT) ? 2000 : ERS_T;
    for (int s = 0; s < 128; s++)
      if (m[s] && s[6:0] != PROT)
        for (int i = 0; i < 4096; i++) mem[{s[6:0], i[11:0]}] = 8'hff;
  endtask
  task automatic do_wr(input [19:0] a, input [7:0] d);
    if (d == 8'hf0 && (!rb_oe || pfail)) begin
      {cyc, prog_left} = '0;
      {auto, pfail} = '0;
    end else if (rb_oe) begin
      if (d == 8'hb0 && ers_left > 0 && prog_left == 0) susp = 1'b1;
    end else if (byp) begin
      if (cyc == 3) prog(a, d);
      else if (cyc == 9) begin
        byp = d != 8'h00;
        cyc = 0;
      end else cyc = d == 8'ha0 ? 3 : (d == 8'h90 ? 9 : 0);
    end else if (susp && cyc == 0 && d == 8'h30) susp = 1'b0;
    else case (cyc)
      0: cyc = a[10:0] == 11'h555 && d == 8'haa ? 1 : 0;
      1: cyc = a[10:0] == 11'h2aa && d == 8'h55 ? 2 : 0;
      2: begin
        auto = d == 8'h90;
        byp = d == 8'h20;
        cyc = d == 8'ha0 ? 3 : (d == 8'h80 ? 4 : 0);
      end
      3: prog(a, d);
      4: cyc = d == 8'haa ? 5 : 0;
      5: cyc = d == 8'h55 ? 6 : 0;
      default: begin
        cyc = 0;
        if (d == 8'h10) erase({128{1'b1}});
        if (d == 8'h30) erase(128'd1 << a[18:12]);
      end
    endcase
  endtask
endmodule

// >>> tb/tb_fwsr_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`include "fwsr_defs.vh"
module tb_fwsr_host;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [19:0] fl_addr;
  logic [7:0]  fl_dq_out, fl_dq_in, mdl_q;
  logic        fl_dq_oe, fl_chip_sel_n, fl_write_en_n, fl_out_en_n, rb_oe;
  int          num_errors, check_count, cycles, rb_low, t0;
  // Open-drain ready line with pull-up
  wire         ready_busy_in = rb_oe ? 1'b0 : 1'b1;
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : mdl_q;
  fwsr_host fwsr_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in), .fl_chip_sel_n(fl_chip_sel_n),
    .fl_write_en_n(fl_write_en_n), .fl_out_en_n(fl_out_en_n), .ready_busy_in(ready_busy_in));
  fwsr_flash_mdl fwsr_flash_mdl_i (.addr(fl_addr), .dq_in(fl_dq_out), .cs_n(fl_chip_sel_n),
    .we_n(fl_write_en_n), .oe_n(fl_out_en_n), .dq_o(mdl_q), .rb_oe(rb_oe));
  // ==========
  // Clock, timeout and bus tasks
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (!ready_busy_in) rb_low++;
    if (cycles == 30000) begin
      num_errors++;
      $display("unexpected at %0t: run timed out", $time);
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issue one command and wait for done with busy clear
  task automatic run(input logic [3:0] c, input logic [19:0] a, input logic [7:0] d);
    apb(1'b1, `FWSR_REG_ADDR, {12'h000, a});
    apb(1'b1, `FWSR_REG_DATA, {24'h000000, d});
    apb(1'b1, `FWSR_REG_CTRL, {28'h0000000, c});
    t0 = cycles;
    do apb(1'b0, `FWSR_REG_STATUS, 32'h0); while (st[1:0] !== 2'b10);
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    run(`FWSR_CMD_READ, a, 8'h00);
    apb(1'b0, `FWSR_REG_RDATA, 32'h0);
    chk(st, {24'h000000, e});
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    apb(1'b0, `FWSR_REG_STATUS, 32'h0);
    chk(st, 32'h00000008);
    apb(1'b1, 12'h020, 32'h0000ffff);
    apb(1'b0, 12'h020, 32'h0);
    chk(st, 32'h00000000);
    rd(20'h01234, 8'hff);
    $display("test reset done");
  endtask
  task automatic t_prog;
    rb_low = 0;
    run(`FWSR_CMD_PROGRAM, 20'h01234, 8'h5a);
    chk(st & 32'h7, 32'h2);
    chk({31'h0, rb_low > 0}, 32'h1);
    chk({24'h0, fwsr_flash_mdl_i.mem[19'h01234]}, 32'h5a);
    run(`FWSR_CMD_PROGRAM, 20'h02010, 8'h33);
    rd(20'h01234, 8'h5a);
    run(`FWSR_CMD_PROGRAM, 20'h05010, 8'h00);
    chk(st & 32'hf, 32'ha);
    rd(20'h05010, 8'hff);
    $display("test program done");
  endtask
  task automatic t_autosel;
    run(`FWSR_CMD_AUTOSEL, 20'h05002, 8'h00);
    apb(1'b0, `FWSR_REG_RDATA, 32'h0);
    chk(st, 32'h1);
    run(`FWSR_CMD_RESET, 20'h00000, 8'h00);
    run(`FWSR_CMD_AUTOSEL, 20'h01002, 8'h00);
    apb(1'b0, `FWSR_REG_RDATA, 32'h0);
    chk(st, 32'h0);
    run(`FWSR_CMD_RESET, 20'h00000, 8'h00);
    rd(20'h01234, 8'h5a);
    $display("test autoselect done");
  endtask
  task automatic t_bypass;
    run(`FWSR_CMD_BYP_PROG, 20'h03000, 8'h11);
    chk(st & 32'h7, 32'h6);
    run(`FWSR_CMD_BYP_ENTER, 20'h00000, 8'h00);
    chk(st & 32'h17, 32'h12);
    run(`FWSR_CMD_BYP_PROG, 20'h03000, 8'h11);
    chk(st & 32'h7, 32'h2);
    run(`FWSR_CMD_BYP_EXIT, 20'h00000, 8'h00);
    chk(st & 32'h17, 32'h2);
    rd(20'h03000, 8'h11);
    $display("test bypass done");
  endtask
  task automatic t_erase;
    run(`FWSR_CMD_SECT_ERS, 20'h01000, 8'h00);
    chk(st & 32'h7, 32'h2);
    apb(1'b0, `FWSR_REG_SECTOR, 32'h0);
    chk(st, 32'h1);
    rd(20'h01234, 8'hff);
    rd(20'h02010, 8'h33);
    run(`FWSR_CMD_RESUME, 20'h00000, 8'h00);
    chk(st & 32'h7, 32'h6);
    run(`FWSR_CMD_SECT_ERS, 20'h05000, 8'h00);
    chk({31'h0, cycles - t0 >= 2000}, 32'h1);
    $display("test erase done");
  endtask
  task automatic t_fail;
    run(`FWSR_CMD_PROGRAM, 20'h04000, 8'h00);
    run(`FWSR_CMD_PROGRAM, 20'h04000, 8'h80);
    chk(st & 32'h7, 32'h6);
    run(`FWSR_CMD_RESET, 20'h00000, 8'h00);
    chk(st & 32'h7, 32'h2);
    rd(20'h04000, 8'h00);
    run(`FWSR_CMD_CHIP_ERS, 20'h00000, 8'h00);
    rd(20'h02010, 8'hff);
    run(`FWSR_CMD_POLL, 20'h02010, 8'h00);
    chk(st & 32'h7, 32'h2);
    run(`FWSR_CMD_SUSPEND, 20'h00000, 8'h00);
    chk(st & 32'h1, 32'h0);
    $display("test fail and chip erase done");
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'b0000;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_prog;
    t_autosel;
    t_bypass;
    t_erase;
    t_fail;
    end_sim;
  end
endmodule
